/* File: rtl/trt_map.svh */
// Register offsets, field positions, reset values and timing counts of the timer rate and third timer block
`ifndef TRT_MAP_SVH
`define TRT_MAP_SVH

// ==========================================================
// Register addresses
`define TRT_ADDR_RATE_CTRL 8'h8e
`define TRT_ADDR_CONTROL 8'hc8
`define TRT_ADDR_RELOAD_LOW 8'hca
`define TRT_ADDR_RELOAD_HIGH 8'hcb
`define TRT_ADDR_COUNT_LOW 8'hcc
`define TRT_ADDR_COUNT_HIGH 8'hcd

// ==========================================================
// Rate control fields
`define TRT_BIT_THIRD_FAST 5
`define TRT_BIT_SECOND_FAST 4
`define TRT_BIT_FIRST_FAST 3
`define TRT_RATE_CTRL_RESET 8'h00
`define TRT_RATE_CTRL_MASK 8'h3f

// ==========================================================
// Third timer control fields
`define TRT_BIT_OVF_FLAG 7
`define TRT_BIT_EXT_FLAG 6
`define TRT_BIT_RX_CLK_SEL 5
`define TRT_BIT_TX_CLK_SEL 4
`define TRT_BIT_EXT_EN 3
`define TRT_BIT_RUN 2
`define TRT_BIT_CNT_SEL 1
`define TRT_BIT_CAP_SEL 0
`define TRT_CONTROL_RESET 8'h00

// ==========================================================
// Timing counts in core clock cycles
`define TRT_SLOW_DIV 12
`define TRT_FAST_DIV 4
`define TRT_BAUD_DIV 2

`endif

/* File: rtl/trt_pkg.sv */
// Types of the timer rate and third timer block
package trt_pkg;
	typedef enum logic [3:0] {
		TRT_OFF = 4'b0001,
		TRT_CAPTURE = 4'b0010,
		TRT_RELOAD = 4'b0100,
		TRT_BAUD = 4'b1000
	} trt_mode_t;
endpackage

/* File: rtl/trt_timer.sv */
// Timer rate selection and the complete third timer with capture, reload and baud modes
`timescale 1ns/1ps
`include "trt_map.svh"

module trt_timer #(
	parameter int SLOW_DIV = `TRT_SLOW_DIV,
	parameter int FAST_DIV = `TRT_FAST_DIV,
	parameter int BAUD_DIV = `TRT_BAUD_DIV
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Special function register port
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	// Timer pins
	input wire logic external_count_pin,
	input wire logic trigger_pin,
	output logic overflow_output_pin,
	// Rate ticks for the first and second timers
	output logic first_timer_tick,
	output logic second_timer_tick,
	// Serial port 0 clocking
	input wire logic second_timer_overflow,
	output logic serial_rx_clock,
	output logic serial_tx_clock,
	// Interrupt request line to the core
	output logic third_timer_irq
);

	// ==========================================================
	// Registers
	logic [7:0] rate_reg;
	logic [7:0] control_reg;
	logic [15:0] reload_reg;
	logic [15:0] count_reg;
	logic [15:0] count_next;
	logic [3:0] div_slow_reg;
	logic [1:0] div_fast_reg;
	logic div_baud_reg;
	logic [1:0] cnt_sync_reg;
	logic [1:0] trg_sync_reg;
	logic cnt_prev_reg;
	logic trg_prev_reg;
	logic force_irq_reg;
	trt_pkg::trt_mode_t mode;
	logic tick_slow;
	logic tick_fast;
	logic tick_baud;
	logic cnt_fall;
	logic trg_fall;
	logic advance;
	logic rollover;
	logic trig_act;
	logic ext_set;
	logic wr_ctrl;
	logic third_fast;
	logic clk_sel;

	function automatic logic sel(input logic [7:0] a, input logic [7:0] b);
		return a == b;
	endfunction

	assign third_fast = rate_reg[`TRT_BIT_THIRD_FAST];
	assign clk_sel = control_reg[`TRT_BIT_RX_CLK_SEL] | control_reg[`TRT_BIT_TX_CLK_SEL];
	assign wr_ctrl = sfr_wr && sel(sfr_addr, `TRT_ADDR_CONTROL);

	// ==========================================================
	// Mode decode
	always_comb begin
		if (!control_reg[`TRT_BIT_RUN]) begin
			mode = trt_pkg::TRT_OFF;
		end else if (clk_sel) begin
			mode = trt_pkg::TRT_BAUD;
		end else if (control_reg[`TRT_BIT_CAP_SEL]) begin
			mode = trt_pkg::TRT_CAPTURE;
		end else begin
			mode = trt_pkg::TRT_RELOAD;
		end
	end

	// ==========================================================
	// Core clock dividers
	always_ff @(posedge ref_clk) begin
		if (srst || div_slow_reg == 4'(SLOW_DIV - 1)) begin
			div_slow_reg <= 4'h0;
		end else begin
			div_slow_reg <= div_slow_reg + 4'h1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst || div_fast_reg == 2'(FAST_DIV - 1)) begin
			div_fast_reg <= 2'h0;
		end else begin
			div_fast_reg <= div_fast_reg + 2'h1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst || div_baud_reg == 1'(BAUD_DIV - 1)) begin
			div_baud_reg <= 1'b0;
		end else begin
			div_baud_reg <= 1'b1;
		end
	end

	assign tick_slow = div_slow_reg == 4'(SLOW_DIV - 1);
	assign tick_fast = div_fast_reg == 2'(FAST_DIV - 1);
	assign tick_baud = div_baud_reg == 1'(BAUD_DIV - 1);

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			first_timer_tick <= 1'b0;
			second_timer_tick <= 1'b0;
		end else begin
			first_timer_tick <= rate_reg[`TRT_BIT_FIRST_FAST] ? tick_fast : tick_slow;
			second_timer_tick <= rate_reg[`TRT_BIT_SECOND_FAST] ? tick_fast : tick_slow;
		end
	end

	// ==========================================================
	// Pin synchronisers and fall detect
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cnt_sync_reg <= 2'b11;
			trg_sync_reg <= 2'b11;
			cnt_prev_reg <= 1'b1;
			trg_prev_reg <= 1'b1;
		end else begin
			cnt_sync_reg <= {cnt_sync_reg[0], external_count_pin};
			trg_sync_reg <= {trg_sync_reg[0], trigger_pin};
			cnt_prev_reg <= cnt_sync_reg[1];
			trg_prev_reg <= trg_sync_reg[1];
		end
	end

	assign cnt_fall = cnt_prev_reg && !cnt_sync_reg[1];
	assign trg_fall = trg_prev_reg && !trg_sync_reg[1] && control_reg[`TRT_BIT_EXT_EN];

	// ==========================================================
	// Count advance
	always_comb begin
		if (mode == trt_pkg::TRT_OFF) begin
			advance = 1'b0;
		end else if (control_reg[`TRT_BIT_CNT_SEL]) begin
			advance = cnt_fall;
		end else if (mode == trt_pkg::TRT_BAUD) begin
			advance = tick_baud;
		end else begin
			advance = third_fast ? tick_fast : tick_slow;
		end
	end

	assign rollover = advance && count_reg == 16'hffff;
	assign trig_act = trg_fall && mode != trt_pkg::TRT_BAUD && mode != trt_pkg::TRT_OFF;
	// Baud mode takes no trigger reload but still flags the trigger fall
	assign ext_set = trg_fall && mode != trt_pkg::TRT_OFF;

	always_comb begin
		count_next = count_reg;
		if (rollover) begin
			if (mode == trt_pkg::TRT_CAPTURE) begin
				count_next = 16'h0000;
			end else begin
				count_next = reload_reg;
			end
		end else if (advance) begin
			count_next = count_reg + 16'h0001;
		end
		if (trig_act && mode == trt_pkg::TRT_RELOAD) begin
			count_next = reload_reg;
		end
	end

	// ==========================================================
	// Register writes and hardware updates
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rate_reg <= `TRT_RATE_CTRL_RESET;
		end else if (sfr_wr && sel(sfr_addr, `TRT_ADDR_RATE_CTRL)) begin
			rate_reg <= sfr_wdata & `TRT_RATE_CTRL_MASK;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			count_reg <= 16'h0000;
		end else if (sfr_wr && sel(sfr_addr, `TRT_ADDR_COUNT_LOW)) begin
			count_reg <= {count_reg[15:8], sfr_wdata};
		end else if (sfr_wr && sel(sfr_addr, `TRT_ADDR_COUNT_HIGH)) begin
			count_reg <= {sfr_wdata, count_reg[7:0]};
		end else begin
			count_reg <= count_next;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			reload_reg <= 16'h0000;
		end else if (trig_act && mode == trt_pkg::TRT_CAPTURE) begin
			reload_reg <= count_reg;
		end else if (sfr_wr && sel(sfr_addr, `TRT_ADDR_RELOAD_LOW)) begin
			reload_reg <= {reload_reg[15:8], sfr_wdata};
		end else if (sfr_wr && sel(sfr_addr, `TRT_ADDR_RELOAD_HIGH)) begin
			reload_reg <= {sfr_wdata, reload_reg[7:0]};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			control_reg <= `TRT_CONTROL_RESET;
		end else begin
			if (wr_ctrl) begin
				control_reg <= sfr_wdata;
			end
			if (rollover && !clk_sel) begin
				control_reg[`TRT_BIT_OVF_FLAG] <= 1'b1;
			end
			if (ext_set) begin
				control_reg[`TRT_BIT_EXT_FLAG] <= 1'b1;
			end
		end
	end

	// One-cycle request when software writes 1 to a flag
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			force_irq_reg <= 1'b0;
		end else begin
			force_irq_reg <= wr_ctrl && (sfr_wdata[`TRT_BIT_OVF_FLAG] | sfr_wdata[`TRT_BIT_EXT_FLAG]);
		end
	end

	// ==========================================================
	// Outputs
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			overflow_output_pin <= 1'b0;
			serial_rx_clock <= 1'b0;
			serial_tx_clock <= 1'b0;
			third_timer_irq <= 1'b0;
		end else begin
			overflow_output_pin <= rollover;
			serial_rx_clock <= control_reg[`TRT_BIT_RX_CLK_SEL] ? rollover : second_timer_overflow;
			serial_tx_clock <= control_reg[`TRT_BIT_TX_CLK_SEL] ? rollover : second_timer_overflow;
			third_timer_irq <= control_reg[`TRT_BIT_OVF_FLAG] | control_reg[`TRT_BIT_EXT_FLAG] | force_irq_reg;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sfr_rdata <= 8'h00;
		end else begin
			unique case (sfr_addr)
				`TRT_ADDR_RATE_CTRL: sfr_rdata <= rate_reg;
				`TRT_ADDR_CONTROL: sfr_rdata <= control_reg;
				`TRT_ADDR_RELOAD_LOW: sfr_rdata <= reload_reg[7:0];
				`TRT_ADDR_RELOAD_HIGH: sfr_rdata <= reload_reg[15:8];
				`TRT_ADDR_COUNT_LOW: sfr_rdata <= count_reg[7:0];
				`TRT_ADDR_COUNT_HIGH: sfr_rdata <= count_reg[15:8];
				default: sfr_rdata <= 8'h00;
			endcase
		end
	end

	// ==========================================================
	// Checks
	overflow_pulse_a: assert property (@(posedge ref_clk) disable iff (srst) rollover |=> overflow_output_pin ##1 !overflow_output_pin || $past(rollover, 1) && rollover) else $error("Overflow pin not pulsed");
	overflow_flag_set_a: assert property (@(posedge ref_clk) disable iff (srst) rollover && !clk_sel |=> control_reg[`TRT_BIT_OVF_FLAG]) else $error("Overflow flag not set");
	baud_no_flag_a: assert property (@(posedge ref_clk) disable iff (srst) clk_sel && !wr_ctrl && !control_reg[`TRT_BIT_OVF_FLAG] |=> !control_reg[`TRT_BIT_OVF_FLAG] || $past(wr_ctrl)) else $error("Overflow flag set in baud mode");
	run_hold_a: assert property (@(posedge ref_clk) disable iff (srst) !control_reg[`TRT_BIT_RUN] && !sfr_wr |=> $stable(count_reg)) else $error("Count moved while stopped");
	reload_on_roll_a: assert property (@(posedge ref_clk) disable iff (srst) rollover && mode != trt_pkg::TRT_CAPTURE && !sfr_wr |=> count_reg == $past(reload_reg)) else $error("No reload on rollover");
	capture_copy_a: assert property (@(posedge ref_clk) disable iff (srst) trig_act && mode == trt_pkg::TRT_CAPTURE |=> reload_reg == $past(count_reg)) else $error("Capture missed");
	ext_flag_set_a: assert property (@(posedge ref_clk) disable iff (srst) trig_act |=> control_reg[`TRT_BIT_EXT_FLAG]) else $error("External flag not set");
	slow_rate_a: assert property (@(posedge ref_clk) disable iff (srst) tick_slow |=> !tick_slow [*8] ##0 1'b1) else $error("Slow tick spacing wrong");
	rate_reset_a: assert property (@(posedge ref_clk) $past(srst) |-> rate_reg == 8'h00) else $error("Rate bits not cleared");
	irq_force_a: assert property (@(posedge ref_clk) disable iff (srst) wr_ctrl && sfr_wdata[`TRT_BIT_EXT_FLAG] |=> ##1 third_timer_irq) else $error("Forced interrupt missing");

	// ==========================================================
	// Counting checks
	baud_rate_a: assert property (@(posedge ref_clk) disable iff (srst)
		mode == trt_pkg::TRT_BAUD && !control_reg[`TRT_BIT_CNT_SEL] && tick_baud && !sfr_wr && count_reg != 16'hffff
		|=> count_reg == $past(count_reg) + 16'h0001)
		else $error("Baud count did not advance");

	slow_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
		(mode == trt_pkg::TRT_CAPTURE || mode == trt_pkg::TRT_RELOAD) && !control_reg[`TRT_BIT_CNT_SEL]
		&& !third_fast && !tick_slow && !trig_act && !sfr_wr
		|=> $stable(count_reg))
		else $error("Count moved between slow ticks");

	pin_count_a: assert property (@(posedge ref_clk) disable iff (srst)
		control_reg[`TRT_BIT_RUN] && control_reg[`TRT_BIT_CNT_SEL] && cnt_fall && count_reg != 16'hffff
		&& !trig_act && !sfr_wr
		|=> count_reg == $past(count_reg) + 16'h0001)
		else $error("Count pin fall not counted");

	forced_reload_a: assert property (@(posedge ref_clk) disable iff (srst)
		trig_act && mode == trt_pkg::TRT_RELOAD && !sfr_wr
		|=> count_reg == $past(reload_reg))
		else $error("Trigger reload missed");

	// ==========================================================
	// Flag and trigger checks
	trig_ignore_a: assert property (@(posedge ref_clk) disable iff (srst)
		!control_reg[`TRT_BIT_EXT_EN] && !control_reg[`TRT_BIT_EXT_FLAG] && !wr_ctrl
		|=> !control_reg[`TRT_BIT_EXT_FLAG])
		else $error("External flag set while disabled");

	baud_ext_flag_a: assert property (@(posedge ref_clk) disable iff (srst)
		ext_set && mode == trt_pkg::TRT_BAUD
		|=> control_reg[`TRT_BIT_EXT_FLAG])
		else $error("Baud trigger flag missing");

	irq_level_a: assert property (@(posedge ref_clk) disable iff (srst)
		control_reg[`TRT_BIT_OVF_FLAG] || control_reg[`TRT_BIT_EXT_FLAG]
		|=> third_timer_irq)
		else $error("Interrupt level missing");

	// ==========================================================
	// Output, reserved rate bit and mode checks
	overflow_quiet_a: assert property (@(posedge ref_clk) disable iff (srst)
		!rollover
		|=> !overflow_output_pin)
		else $error("Overflow pin high without rollover");

	rx_route_a: assert property (@(posedge ref_clk) disable iff (srst)
		1'b1
		|=> serial_rx_clock == ($past(control_reg[`TRT_BIT_RX_CLK_SEL]) ? $past(rollover) : $past(second_timer_overflow)))
		else $error("Receive clock routed wrong");

	tx_route_a: assert property (@(posedge ref_clk) disable iff (srst)
		1'b1
		|=> serial_tx_clock == ($past(control_reg[`TRT_BIT_TX_CLK_SEL]) ? $past(rollover) : $past(second_timer_overflow)))
		else $error("Transmit clock routed wrong");

	rate_reserved_a: assert property (@(posedge ref_clk) disable iff (srst)
		1'b1
		|-> rate_reg[7:6] == 2'b00)
		else $error("Reserved rate bits set");

	baud_mode_a: assert property (@(posedge ref_clk) disable iff (srst)
		control_reg[`TRT_BIT_RUN] && clk_sel
		|-> mode == trt_pkg::TRT_BAUD)
		else $error("Clock select did not force baud mode");

endmodule

/* File: tb/trt_core_model.sv */
// Far side model: second timer overflow source and serial port 0 clock counters
`timescale 1ns/1ps
module trt_core_model #(
	parameter int OVF_PERIOD = 50
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Serial port 0 clocking
	output logic second_timer_overflow,
	input wire logic serial_rx_clock,
	input wire logic serial_tx_clock,
	// Shift clock counts seen by the serial port
	output logic [15:0] rx_count,
	output logic [15:0] tx_count
);
	int div_reg;
	// ==========================================================
	// Second timer overflow, one pulse each period
	always_ff @(posedge ref_clk) begin
		if (srst || div_reg == OVF_PERIOD - 1) begin
			div_reg <= 0;
		end else begin
			div_reg <= div_reg + 1;
		end
		second_timer_overflow <= !srst && div_reg == OVF_PERIOD - 1;
	end
	// ==========================================================
	// Shift clock counters
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rx_count <= 16'h0000;
			tx_count <= 16'h0000;
		end else begin
			rx_count <= rx_count + 16'(serial_rx_clock === 1'b1);
			tx_count <= tx_count + 16'(serial_tx_clock === 1'b1);
		end
	end
endmodule

/* File: tb/tb_trt_timer.sv */
// Testbench of the timer rate and third timer block
`timescale 1ns/1ps
module tb_trt_timer;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] sfr_addr = 8'h00;
	logic sfr_wr = 1'b0;
	logic [7:0] sfr_wdata = 8'h00;
	logic external_count_pin = 1'b1;
	logic trigger_pin = 1'b1;
	logic [7:0] sfr_rdata;
	logic overflow_output_pin, first_timer_tick, second_timer_tick, second_timer_overflow;
	logic serial_rx_clock, serial_tx_clock, third_timer_irq;
	logic [15:0] rx_count, tx_count, rx0, tx0;
	int n_fail = 0;
	int n_tests = 0;
	int cycles = 0;
	int n;
	logic [7:0] d;
	always #10 ref_clk = ~ref_clk;
	trt_timer dut (.ref_clk(ref_clk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata), .external_count_pin(external_count_pin), .trigger_pin(trigger_pin),
		.overflow_output_pin(overflow_output_pin), .first_timer_tick(first_timer_tick),
		.second_timer_tick(second_timer_tick), .second_timer_overflow(second_timer_overflow),
		.serial_rx_clock(serial_rx_clock), .serial_tx_clock(serial_tx_clock), .third_timer_irq(third_timer_irq));
	trt_core_model partner (.ref_clk(ref_clk), .srst(srst), .second_timer_overflow(second_timer_overflow),
		.serial_rx_clock(serial_rx_clock), .serial_tx_clock(serial_tx_clock), .rx_count(rx_count), .tx_count(tx_count));
	// ==========================================================
	// Checking and closing
	task results;
		$display("tests %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task rng(input string what, input int lo, input int hi, input int got);
		n_tests++;
		if (got < lo || got > hi) begin
			n_fail++;
			$display("wrong value %s expected %0d to %0d seen %0d", what, lo, hi, got);
		end
	endtask
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			n_fail++;
			results();
		end
	end
	// ==========================================================
	// Register port and pin tasks
	task cyc;
		@(posedge ref_clk);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		sfr_addr <= a;
		sfr_wdata <= v;
		sfr_wr <= 1'b1;
		@(posedge ref_clk);
		sfr_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		sfr_addr <= a;
		cyc();
		v = sfr_rdata;
	endtask
	task fall(input bit on_trigger);
		@(posedge ref_clk);
		if (on_trigger) trigger_pin <= 1'b0; else external_count_pin <= 1'b0;
		repeat (6) cyc();
		@(posedge ref_clk);
		if (on_trigger) trigger_pin <= 1'b1; else external_count_pin <= 1'b1;
		repeat (6) cyc();
	endtask
	task gap(input bit second, output int p);
		p = 0;
		repeat (2) do cyc(); while ((second ? second_timer_tick : first_timer_tick) !== 1'b1);
		do begin
			cyc();
			p++;
		end while ((second ? second_timer_tick : first_timer_tick) !== 1'b1 && p < 40);
	endtask
	task wait_ovf(output int p);
		p = 0;
		do begin
			cyc();
			p++;
		end while (overflow_output_pin !== 1'b1 && p < 400);
	endtask
	// ==========================================================
	// Test sequence
	initial begin
		repeat (4) @(posedge ref_clk);
		srst <= 1'b0;
		rd(8'h8e, d); chk("rate reset", 8'h00, d);
		rd(8'hc8, d); chk("control reset", 8'h00, d);
		rd(8'h55, d); chk("unmapped", 8'h00, d);
		wr(8'h8e, 8'h08); rd(8'h8e, d); chk("rate bits", 8'h08, d);
		gap(0, n); chk("first fast gap", 4, n);
		gap(1, n); chk("second slow gap", 12, n);
		wr(8'h8e, 8'h10);
		gap(1, n); chk("second fast gap", 4, n);
		gap(0, n); chk("first slow gap", 12, n);
		wr(8'h8e, 8'h00);
		wr(8'hca, 8'h10); wr(8'hcb, 8'h20); wr(8'hcc, 8'hfe); wr(8'hcd, 8'hff);
		repeat (30) cyc();
		rd(8'hcc, d); chk("held count", 8'hfe, d);
		wr(8'hc8, 8'h04); wait_ovf(n); rng("slow rollover time", 13, 27, n);
		cyc(); chk("overflow pulse width", 1'b0, overflow_output_pin);
		rd(8'hc8, d); chk("overflow flag", 8'h84, d);
		chk("overflow irq", 1'b1, third_timer_irq);
		wr(8'hc8, 8'h00);
		rd(8'hcc, d); chk("reload low", 8'h10, d);
		rd(8'hcd, d); chk("reload high", 8'h20, d);
		wr(8'h8e, 8'h20); wr(8'hcc, 8'hf0); wr(8'hcd, 8'hff);
		wr(8'hc8, 8'h04); wait_ovf(n); rng("fast rollover time", 56, 70, n);
		wr(8'hc8, 8'h00);
		wr(8'hca, 8'hf0); wr(8'hcb, 8'hff); wr(8'hcc, 8'hf0); wr(8'hcd, 8'hff);
		wr(8'hc8, 8'h35);
		rx0 = rx_count;
		tx0 = tx_count;
		repeat (320) cyc();
		rng("baud rx clocks", 9, 11, int'(rx_count - rx0));
		rng("baud tx clocks", 9, 11, int'(tx_count - tx0));
		rd(8'hc8, d); chk("baud no flag", 8'h35, d);
		wr(8'hc8, 8'h00);
		rx0 = rx_count;
		tx0 = tx_count;
		repeat (500) cyc();
		rng("second timer rx clocks", 9, 11, int'(rx_count - rx0));
		rng("second timer tx clocks", 9, 11, int'(tx_count - tx0));
		wr(8'hcc, 8'h34); wr(8'hcd, 8'h12); wr(8'hc8, 8'h0f);
		fall(1);
		rd(8'hca, d); chk("capture low", 8'h34, d);
		rd(8'hcb, d); chk("capture high", 8'h12, d);
		rd(8'hc8, d); chk("external flag", 8'h4f, d);
		chk("external irq", 1'b1, third_timer_irq);
		repeat (3) fall(0);
		rd(8'hcc, d); chk("pin count", 8'h37, d);
		wr(8'hc8, 8'h0e);
		fall(1);
		rd(8'hcc, d); chk("forced reload", 8'h34, d);
		wr(8'hcc, 8'h99); wr(8'hc8, 8'h06);
		fall(1);
		rd(8'hcc, d); chk("trigger ignored", 8'h99, d);
		rd(8'hc8, d); chk("no external flag", 8'h06, d);
		wr(8'hc8, 8'h30); wr(8'hcc, 8'hf0); wr(8'hcd, 8'hff); wr(8'hc8, 8'h3c);
		fall(1);
		rd(8'hc8, d); chk("baud trigger flag", 8'h7c, d);
		wr(8'hc8, 8'h80); cyc();
		chk("software irq", 1'b1, third_timer_irq);
		wr(8'hc8, 8'h00); repeat (2) cyc();
		chk("irq cleared", 1'b0, third_timer_irq);
		results();
	end
endmodule
